/* File: core/lcd_cmd_pkg.sv */
// constants, encodings and types for the lcd command decoder
package lcd_cmd_pkg;
    // opcode fields, compared against the top bits or the whole of a command byte
    localparam logic [5:0] OP_PAGE_TOP6   = 6'h2e; // 101110xx
    localparam logic [2:0] OP_START_TOP3  = 3'h6;  // 110xxxxx
    localparam logic [6:0] OP_ONOFF_TOP7  = 7'h57; // 1010111x
    localparam logic [6:0] OP_ADC_TOP7    = 7'h50; // 1010000x
    localparam logic [6:0] OP_STATIC_TOP7 = 7'h52; // 1010010x
    localparam logic [6:0] OP_DUTY_TOP7   = 7'h54; // 1010100x
    localparam logic [7:0] OP_RMW_ON      = 8'he0;
    localparam logic [7:0] OP_RMW_END     = 8'hee;
    localparam logic [7:0] OP_SOFT_RESET  = 8'he2;

    // address ranges and reset values
    localparam logic [6:0] COL_LIMIT      = 7'h50; // column stops here (80)
    localparam logic [6:0] COL_STEP       = 7'h01;
    localparam logic [1:0] PAGE_AFTER_RST = 2'h3;
    localparam logic [4:0] START_AFTER_RST = 5'h00;
    localparam int         PAGES          = 4;
    localparam int         COLUMNS        = 80;
    localparam logic [3:0] STATUS_LOW     = 4'h0;

    // write fifo: page, column, data
    localparam int FIFO_W     = 17;
    localparam int FIFO_DEPTH = 4;

    // reset-in-progress time after a soft reset or pin reset
    localparam int CLK_PERIOD_NS = 100;
    localparam int RESET_TIME_NS = 1000;
    localparam int RESET_CYCLES  = (RESET_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0] RESET_COUNT = 4'(RESET_CYCLES);

    typedef enum logic [3:0] {
        CMD_NONE, CMD_PAGE, CMD_COLUMN, CMD_START, CMD_ONOFF, CMD_ADC,
        CMD_STATIC, CMD_DUTY, CMD_RMW_ON, CMD_RMW_END, CMD_SOFT_RESET
    } cmd_t;

    typedef enum logic {ST_RUN, ST_RESET} mode_t;
endpackage : lcd_cmd_pkg

/* File: core/lcd_driver_command_decoder.sv */
// lcd command decoder, status byte, display ram and write fifo
//
// Notes on behaviour
// - command 101110xx loads the two-bit page register
// - page register only steers processor access, never the shown image
// - command with bit 7 clear loads the seven-bit column register
// - each data write taken by the fifo, and each data read made while not busy outside rmw, bumps the column, stopping at 80; page never advances
// - command-side read returns busy, segment order, blank, resetting, zeros
// - busy is high while executing or resetting; commands then refused
// - segment order flag 1 means normal column order, 0 reversed
// - blank flag is the inverse of the display on bit
// - resetting flag high during hardware or software reset
// - data write stores the byte at page and column, then bumps column
// - data read outputs old latch, refills latch from ram, bumps column
// - a0h/a1h choose normal or reversed segment order
// - a4h/a5h clear or set static drive, all rows selected
// - a8h/a9h choose 1/16 or 1/32 duty
// - e0h enters read-modify-write, saves column, reads stop bumping
// - eeh leaves read-modify-write and restores the saved column
// - e2h clears start line and sets page 3, ram untouched
// - static drive with display off enters power save
// - power save ends when display turns on or static drops
// - aeh/afh clear or set the display on bit; static drive keeps display_on high
// - command 110xxxxx loads the five-bit start line
`timescale 1ns/1ps
`default_nettype none

module lcd_write_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             reset_n,
    // fill side
    input  wire logic             in_valid,
    output var  logic             in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // drain side
    output var  logic             out_valid,
    input  wire logic             out_ready,
    output var  logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW:0]                 wptr;
        logic [AW:0]                 rptr;
    } fifo_state_t;

    fifo_state_t s;
    fifo_state_t next_s;
    logic [AW:0] fill;

    // pointers carry one extra bit so full and empty differ
    always_comb begin
        fill      = s.wptr - s.rptr;
        in_ready  = (fill != (AW+1)'(DEPTH));
        out_valid = (fill != '0);
        out_data  = s.mem[s.rptr[AW-1:0]];
        next_s    = s;
        if (in_valid && in_ready) begin
            next_s.mem[s.wptr[AW-1:0]] = in_data;
            next_s.wptr = s.wptr + 1'b1;
        end
        if (out_valid && out_ready) begin
            next_s.rptr = s.rptr + 1'b1;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end
endmodule : lcd_write_fifo

module lcd_driver_command_decoder
    import lcd_cmd_pkg::*;
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       reset_n,
    // processor bus pins
    input  wire logic       cmd_data_select,
    input  wire logic       rd_n,
    input  wire logic       wr_n,
    input  wire logic [7:0] data_in,
    output var  logic [7:0] data_out,
    output var  logic       data_oe,
    // hardware reset pin, active high
    input  wire logic       power_on_clear_pin,
    // display scan read port
    input  wire logic [1:0] scan_page,
    input  wire logic [6:0] scan_column,
    output var  logic [7:0] scan_data,
    // drive sequencing controls
    output var  logic       display_on,
    output var  logic       segment_normal,
    output var  logic       all_rows_select,
    output var  logic       duty_32,
    output var  logic [4:0] start_line,
    output var  logic       power_save,
    output var  logic       oscillator_output_enable,
    output var  logic       ext_clock_enable
);
    typedef struct packed {
        logic [2:0]      rd_s;
        logic [2:0]      wr_s;
        logic [2:0]      cds_s;
        logic [2:0]      por_s;
        logic [2:0][7:0] din_s;
        logic            rd_lvl;
        logic            wr_lvl;
        logic            por_lvl;
        mode_t           mode;
        logic [3:0]      rst_cnt;
        logic            cmd_busy;
        logic [1:0]      page;
        logic [6:0]      column;
        logic [6:0]      saved_column;
        logic            rmw;
        logic            seg_normal;
        logic            disp_on;
        logic            static_on;
        logic            duty32;
        logic [4:0]      start;
        logic [7:0]      out_latch;
        logic            refill_pend;
        logic [8:0]      refill_addr;
        logic [7:0]      dout;
        logic            doe;
        logic            psave;
        logic            drive_on;
        logic            clk_en;
    } state_t;

    state_t s;
    state_t next_s;

    logic [7:0] ram [PAGES][COLUMNS];
    logic       wf_in_valid;
    logic       wf_in_ready;
    logic [FIFO_W-1:0] wf_in_data;
    logic       wf_out_valid;
    logic       wf_out_ready;
    logic [FIFO_W-1:0] wf_out_data;
    logic       refill_now;
    logic [7:0] refill_word;
    logic       rd_start;
    logic       wr_done;
    logic       busy;
    logic [7:0] status_byte;
    cmd_t       cmd;
    logic [1:0] wf_page;
    logic [6:0] wf_col;
    logic [7:0] wf_byte;

    // classify a command byte; anything unlisted decodes to none
    function automatic cmd_t decode(input logic [7:0] b);
        cmd_t c;
        c = CMD_NONE;
        if (!b[7])                          c = CMD_COLUMN;
        else if (b[7:2] == OP_PAGE_TOP6)    c = CMD_PAGE;
        else if (b[7:5] == OP_START_TOP3)   c = CMD_START;
        else if (b[7:1] == OP_ONOFF_TOP7)   c = CMD_ONOFF;
        else if (b[7:1] == OP_ADC_TOP7)     c = CMD_ADC;
        else if (b[7:1] == OP_STATIC_TOP7)  c = CMD_STATIC;
        else if (b[7:1] == OP_DUTY_TOP7)    c = CMD_DUTY;
        else if (b == OP_RMW_ON)            c = CMD_RMW_ON;
        else if (b == OP_RMW_END)           c = CMD_RMW_END;
        else if (b == OP_SOFT_RESET)        c = CMD_SOFT_RESET;
        return c;
    endfunction : decode

    // address past the last column reads as zero
    function automatic logic [7:0] ram_word(input logic [8:0] a);
        logic [7:0] w;
        w = '0;
        if (a[6:0] < COL_LIMIT) w = ram[a[8:7]][a[6:0]];
        return w;
    endfunction : ram_word

    // pending writes count as busy so a read never overtakes them
    assign busy = s.cmd_busy || (s.mode == ST_RESET) || wf_out_valid;
    assign status_byte = {busy, s.seg_normal, !s.disp_on,
                          s.mode == ST_RESET, STATUS_LOW};
    // a refill claims the single ram port and stalls the fifo drain
    assign refill_now   = s.refill_pend;
    assign wf_out_ready = !refill_now;
    assign refill_word  = ram_word(s.refill_addr);
    // strobe edges read registered stages only, so nothing loops through next_s
    assign rd_start     = s.rd_lvl && (s.rd_s[1] == s.rd_s[2]) && !s.rd_s[2];
    assign wr_done      = !s.wr_lvl && (s.wr_s[1] == s.wr_s[2]) && s.wr_s[2];
    assign cmd          = decode(s.din_s[2]);
    assign wf_in_data   = {s.page, s.column, s.din_s[2]};
    assign wf_in_valid  = wr_done && s.cds_s[2] && (s.mode == ST_RUN);
    assign {wf_page, wf_col, wf_byte} = wf_out_data;

    lcd_write_fifo #(
        .WIDTH (FIFO_W),
        .DEPTH (FIFO_DEPTH)
    ) u_write_fifo (
        .clk       (clk),
        .reset_n   (reset_n),
        .in_valid  (wf_in_valid),
        .in_ready  (wf_in_ready),
        .in_data   (wf_in_data),
        .out_valid (wf_out_valid),
        .out_ready (wf_out_ready),
        .out_data  (wf_out_data)
    );

    // next-state logic for the whole block
    always_comb begin
        next_s = s;
        // pin inputs: three stages, level moves once stages two and three agree
        next_s.rd_s  = {s.rd_s[1:0], rd_n};
        next_s.wr_s  = {s.wr_s[1:0], wr_n};
        next_s.cds_s = {s.cds_s[1:0], cmd_data_select};
        next_s.por_s = {s.por_s[1:0], power_on_clear_pin};
        next_s.din_s = {s.din_s[1:0], data_in};
        if (s.rd_s[1] == s.rd_s[2])   next_s.rd_lvl  = s.rd_s[2];
        if (s.wr_s[1] == s.wr_s[2])   next_s.wr_lvl  = s.wr_s[2];
        if (s.por_s[1] == s.por_s[2]) next_s.por_lvl = s.por_s[2];
        next_s.cmd_busy = 1'b0;

        // bus drive follows the strobe; released once rd goes high again
        if (next_s.rd_lvl) begin
            next_s.doe = 1'b0;
        end
        if (rd_start) begin
            next_s.doe = 1'b1;
            if (!s.cds_s[2]) begin
                next_s.dout = status_byte;
            end else if (!busy && !s.refill_pend) begin
                next_s.dout        = s.out_latch;
                next_s.refill_pend = 1'b1;
                next_s.refill_addr = {s.page, s.column};
                if (!s.rmw && s.column < COL_LIMIT) begin
                    next_s.column = s.column + COL_STEP;
                end
            end else begin
                next_s.dout = s.out_latch;
            end
        end
        // first read after a column load returns a stale latch
        if (refill_now) begin
            next_s.out_latch   = refill_word;
            next_s.refill_pend = 1'b0;
        end

        // display data write: queued, column moves even in rmw mode
        if (wf_in_valid && wf_in_ready && s.column < COL_LIMIT) begin
            next_s.column = s.column + COL_STEP;
        end

        // command write, refused while busy
        if (wr_done && !s.cds_s[2] && !busy) begin
            next_s.cmd_busy = (cmd != CMD_NONE);
            unique case (cmd)
                CMD_PAGE:   next_s.page = s.din_s[2][1:0];
                CMD_COLUMN: next_s.column = s.din_s[2][6:0];
                CMD_START:  next_s.start = s.din_s[2][4:0];
                CMD_ONOFF:  next_s.disp_on = s.din_s[2][0];
                CMD_ADC:    next_s.seg_normal = !s.din_s[2][0];
                CMD_STATIC: next_s.static_on = s.din_s[2][0];
                CMD_DUTY:   next_s.duty32 = s.din_s[2][0];
                CMD_RMW_ON: begin
                    next_s.rmw          = 1'b1;
                    next_s.saved_column = s.column;
                end
                CMD_RMW_END: begin
                    if (s.rmw) begin
                        next_s.column = s.saved_column;
                    end
                    next_s.rmw = 1'b0;
                end
                CMD_SOFT_RESET: begin
                    next_s.start   = START_AFTER_RST;
                    next_s.page    = PAGE_AFTER_RST;
                    next_s.mode    = ST_RESET;
                    next_s.rst_cnt = RESET_COUNT;
                end
                CMD_NONE: ;
            endcase
        end

        // reset sequencer; the pin holds it while high
        unique case (s.mode)
            ST_RUN: ;
            ST_RESET: begin
                if (s.rst_cnt != '0) begin
                    next_s.rst_cnt = s.rst_cnt - 1'b1;
                end else begin
                    next_s.mode = ST_RUN;
                end
            end
        endcase
        if (s.por_lvl) begin
            next_s.mode         = ST_RESET;
            next_s.rst_cnt      = RESET_COUNT;
            next_s.page         = PAGE_AFTER_RST;
            next_s.start        = START_AFTER_RST;
            next_s.column       = '0;
            next_s.rmw          = 1'b0;
            next_s.seg_normal   = 1'b1;
            next_s.disp_on      = 1'b0;
            next_s.static_on    = 1'b0;
            next_s.duty32       = 1'b0;
        end

        // power save is a pure combination of the two mode bits
        next_s.psave = next_s.static_on && !next_s.disp_on;
        // registered copies keep every drive output straight off a flop
        next_s.drive_on = next_s.disp_on || next_s.static_on;
        next_s.clk_en   = !next_s.psave;
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s            <= '0;
            s.rd_s       <= 3'h7;
            s.wr_s       <= 3'h7;
            s.rd_lvl     <= 1'b1;
            s.wr_lvl     <= 1'b1;
            s.mode       <= ST_RESET;
            s.rst_cnt    <= RESET_COUNT;
            s.page       <= PAGE_AFTER_RST;
            s.seg_normal <= 1'b1;
            s.clk_en     <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    // ram: fifo drain writes, scan port reads; scan never uses the page register
    always_ff @(posedge clk) begin
        if (wf_out_valid && wf_out_ready && wf_col < COL_LIMIT) begin
            ram[wf_page][wf_col] <= wf_byte;
        end
        scan_data <= ram_word({scan_page, scan_column});
    end

    // registered outputs
    assign data_out                 = s.dout;
    assign data_oe                  = s.doe;
    assign display_on               = s.drive_on;
    assign segment_normal           = s.seg_normal;
    assign all_rows_select          = s.static_on;
    assign duty_32                  = s.duty32;
    assign start_line               = s.start;
    assign power_save               = s.psave;
    assign oscillator_output_enable = s.clk_en;
    assign ext_clock_enable         = s.clk_en;
endmodule : lcd_driver_command_decoder

`default_nettype wire

/* File: dv/cpu_bus_model.sv */
// processor bus model driving the decoder pins
`timescale 1ns/1ps
`default_nettype none
module cpu_bus_model (
    // clock
    input  wire logic       clk,
    // strobes and write data
    output var  logic       cmd_data_select,
    output var  logic       rd_n,
    output var  logic       wr_n,
    output var  logic [7:0] data_in,
    // read answer
    input  wire logic [7:0] data_out,
    input  wire logic       data_oe
);
    // bus idle at start
    initial begin
        cmd_data_select = 1'b0;
        rd_n            = 1'b1;
        wr_n            = 1'b1;
        data_in         = 8'h00;
    end
    // move just past a rising edge
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step
    // write: data held past the synchroniser, spacing covers sync and action
    task automatic wr(input logic cds, input logic [7:0] v);
        cmd_data_select = cds;
        data_in         = v;
        wr_n            = 1'b0;
        step(4);
        wr_n = 1'b1;
        step(4);
        data_in = ~v; // hold over; a stale copy would hide late sampling
        step(8);
    endtask : wr
    // read: request held until the device drives, taken at that edge
    task automatic rd(input logic cds, output logic [7:0] v);
        int i;
        cmd_data_select = cds;
        rd_n            = 1'b0;
        for (i = 0; i < 20 && data_oe !== 1'b1; i++) begin
            @(posedge clk);
        end
        if (i == 20) begin
            tb_top.fails++;
            tb_top.wrap_up();
        end
        v = data_out;
        #1;
        rd_n = 1'b1;
        step(8);
    endtask : rd
endmodule : cpu_bus_model
`default_nettype wire

/* File: dv/lcd_decoder_monitor.sv */
// port-level assertions for the lcd command decoder
`timescale 1ns/1ps
`default_nettype none
module lcd_decoder_monitor (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       reset_n,
    // processor bus pins
    input  wire logic       cmd_data_select,
    input  wire logic       rd_n,
    input  wire logic [7:0] data_out,
    input  wire logic       data_oe,
    // drive controls
    input  wire logic       segment_normal,
    input  wire logic       display_on,
    input  wire logic       all_rows_select,
    input  wire logic       power_save,
    input  wire logic       oscillator_output_enable,
    input  wire logic       ext_clock_enable
);
    logic oe_q;
    logic stat_rd;
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    // first cycle of a status byte on the bus
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            oe_q <= 1'b0;
        end else begin
            oe_q <= data_oe;
        end
    end
    assign stat_rd = data_oe && !oe_q && !cmd_data_select;
    a_status_low_zero: assert property (stat_rd |-> data_out[3:0] == 4'h0)
        else $error("status low nibble not zero");
    a_bus_release: assert property (rd_n [*6] |-> !data_oe)
        else $error("bus still driven after read");
    a_order_flag: assert property (stat_rd |-> data_out[6] == segment_normal)
        else $error("segment order flag wrong");
    a_blank_flag: assert property (stat_rd && !all_rows_select |->
        data_out[5] != display_on)
        else $error("blank flag wrong");
    a_busy_in_reset: assert property (stat_rd && data_out[4] |-> data_out[7])
        else $error("reset without busy");
    a_static_forces_on: assert property (all_rows_select |-> display_on)
        else $error("static drive without display on");
    a_save_needs_static: assert property (power_save |-> all_rows_select)
        else $error("power save without static drive");
    a_save_stops_clocks: assert property (power_save |->
        !oscillator_output_enable && !ext_clock_enable)
        else $error("clocks alive in power save");
    a_oe_needs_read: assert property ($rose(data_oe) |-> !rd_n)
        else $error("bus driven without a read strobe");
    a_save_exit: assert property ($fell(all_rows_select) |-> ##[0:1] !power_save)
        else $error("power save kept after static off");
endmodule : lcd_decoder_monitor
`default_nettype wire

/* File: dv/tb_top.sv */
// self-checking bench for the lcd command decoder
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    // design pins and bench state
    logic       clk = 1'b0;
    logic       reset_n, power_on_clear_pin, cmd_data_select, rd_n, wr_n, data_oe;
    logic [7:0] data_in, data_out, scan_data, b;
    logic [1:0] scan_page;
    logic [6:0] scan_column;
    logic       display_on, segment_normal, all_rows_select, duty_32, power_save;
    logic       oscillator_output_enable, ext_clock_enable;
    logic [4:0] start_line;
    int         fails = 0;
    int         samples_checked = 0;
    // 10 MHz clock
    always #50 clk = ~clk;
    // device and the processor facing it
    lcd_driver_command_decoder u_lcd_driver_command_decoder (
        .clk, .reset_n, .cmd_data_select, .rd_n, .wr_n, .data_in, .data_out, .data_oe,
        .power_on_clear_pin, .scan_page, .scan_column, .scan_data, .display_on,
        .segment_normal, .all_rows_select, .duty_32, .start_line, .power_save,
        .oscillator_output_enable, .ext_clock_enable
    );
    cpu_bus_model u_cpu_bus_model (
        .clk, .cmd_data_select, .rd_n, .wr_n, .data_in, .data_out, .data_oe
    );
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : check
    task automatic wrap_up;
        if (fails == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : wrap_up
    // poll status until busy drops, bounded
    task automatic idle;
        int i;
        for (i = 0; i < 30; i++) begin
            u_cpu_bus_model.rd(1'b0, b);
            if (b[7] === 1'b0) break;
        end
        if (i == 30) begin
            fails++;
            wrap_up();
        end
    endtask : idle
    task automatic c(input logic [7:0] v);
        idle();
        u_cpu_bus_model.wr(1'b0, v);
    endtask : c
    task automatic w(input logic [7:0] v);
        u_cpu_bus_model.wr(1'b1, v);
    endtask : w
    task automatic st(input logic [7:0] exp);
        u_cpu_bus_model.rd(1'b0, b);
        check(b, exp);
    endtask : st
    // data read; a dummy read is not compared
    task automatic dr(input logic [7:0] exp, input logic used);
        idle();
        u_cpu_bus_model.rd(1'b1, b);
        if (used) check(b, exp);
    endtask : dr
    // look at a ram word through the scan port
    task automatic peek(input logic [1:0] p, input logic [6:0] col, input logic [7:0] exp);
        scan_page   = p;
        scan_column = col;
        u_cpu_bus_model.step(3);
        check(scan_data, exp);
    endtask : peek
    // main sequence
    initial begin
        reset_n            = 1'b0;
        power_on_clear_pin = 1'b1;
        scan_page          = 2'h0;
        scan_column        = 7'h00;
        repeat (20) @(posedge clk);
        #1;
        reset_n = 1'b1;
        u_cpu_bus_model.step(4);
        power_on_clear_pin = 1'b0;
        st(8'hf0);
        c(8'ha1);
        st(8'h20);
        check({7'h0, segment_normal}, 8'h00);
        c(8'ha0);
        c(8'haf);
        st(8'h40);
        c(8'ha5);
        check({6'h0, all_rows_select, display_on}, 8'h03);
        c(8'ha4);
        c(8'ha9);
        check({7'h0, duty_32}, 8'h01);
        c(8'ha8);
        check({7'h0, duty_32}, 8'h00);
        c(8'hd5);
        c(8'hff);
        check({3'h0, start_line}, 8'h15);
        st(8'h40);
        // last two columns of page 1, third write runs off the end
        c(8'hb9);
        c(8'h4e);
        w(8'h11);
        w(8'h22);
        w(8'h33);
        peek(2'h1, 7'h4e, 8'h11);
        peek(2'h1, 7'h4f, 8'h22);
        c(8'h00);
        w(8'h77);
        peek(2'h1, 7'h00, 8'h77);
        c(8'h4e);
        dr(8'h00, 1'b0);
        dr(8'h11, 1'b1);
        dr(8'h22, 1'b1);
        // read-modify-write: reads hold the column, writes still move it
        c(8'h4e);
        c(8'he0);
        dr(8'h00, 1'b0);
        dr(8'h11, 1'b1);
        dr(8'h11, 1'b1);
        w(8'h44);
        w(8'h55);
        peek(2'h1, 7'h4f, 8'h55);
        c(8'hee);
        dr(8'h00, 1'b0);
        dr(8'h44, 1'b1);
        // static drive with display off saves power
        c(8'hae);
        c(8'ha5);
        check({5'h0, power_save, oscillator_output_enable, ext_clock_enable}, 8'h04);
        c(8'haf);
        check({7'h0, power_save}, 8'h00);
        c(8'ha4);
        c(8'he2);
        idle();
        check({3'h0, start_line}, 8'h00);
        c(8'h05);
        w(8'h66);
        peek(2'h3, 7'h05, 8'h66);
        // pin reset in mid-run: status shows resetting, modes fall back
        c(8'ha9);
        power_on_clear_pin = 1'b1;
        u_cpu_bus_model.step(6);
        st(8'hf0);
        power_on_clear_pin = 1'b0;
        idle();
        check({7'h0, duty_32}, 8'h00);
        wrap_up();
    end
endmodule : tb_top
bind lcd_driver_command_decoder lcd_decoder_monitor u_lcd_decoder_monitor (
    .clk, .reset_n, .cmd_data_select, .rd_n, .data_out, .data_oe, .segment_normal,
    .display_on, .all_rows_select, .power_save, .oscillator_output_enable, .ext_clock_enable
);
`default_nettype wire
